// File: hdl/flag_fifo.sv
// Single-clock flagged FIFO with offset register, retransmit and cascade
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module flag_fifo
   import flag_fifo_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEF
)(
   input  wire logic                  CLK,
   input  wire logic                  RESETN,
   input  wire logic                  WRITE_EN_N,
   input  wire logic [DATA_W-1:0]     DATA_IN,
   input  wire logic                  READ_EN_N,
   output var  logic [DATA_W-1:0]     DATA_OUT,
   output var  logic                  DATA_OUT_OE_N,
   input  wire logic                  OUTPUT_ENABLE_N,
   input  wire logic                  OFFSET_LOAD_N,
   output var  logic                  EMPTY_FLAG_N,
   output var  logic                  FULL_FLAG_N,
   output var  logic                  ALMOST_EMPTY_FLAG_N,
   output var  logic                  ALMOST_FULL_FLAG_N,
   output var  logic                  CHAIN_OR_HALF_N,
   output var  logic                  READ_CHAIN_OUT,
   input  wire logic                  WRITE_CHAIN_IN,
   input  wire logic                  READ_CHAIN_IN,
   input  wire logic                  FIRST_LOAD_N,
   input  wire logic                  RETRANSMIT_STROBE,
   input  wire logic                  FLAG_SYNC_SELECT,
   input  wire logic [REG_ADDR_W-1:0] REG_ADDR,
   input  wire logic [REG_DATA_W-1:0] REG_WDATA,
   input  wire logic                  REG_WR,
   input  wire logic                  REG_RD,
   output var  logic [REG_DATA_W-1:0] REG_RDATA
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);
   localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);
   localparam logic [CW-1:0] OFF_RST_C = CW'(OFFSET_RST);

   // The almost-full offset readback field must end inside the data word
   if (DEPTH < 4 || (1 << AW) != DEPTH || DEPTH > 32768)
   begin : g_depth_check
      $error("DEPTH must be a power of two from 4 to 32768");
   end

   typedef struct packed {
      logic [AW-1:0]         wptr;
      logic [AW-1:0]         rptr;
      logic [CW-1:0]         count;
      logic [CW-1:0]         ae_off;
      logic [CW-1:0]         af_off;
      logic                  ld_wsel;
      logic                  ld_rsel;
      logic                  cascade;
      logic                  wown;
      logic                  rown;
      logic [DATA_W-1:0]     q;
      logic                  oe_n;
      logic                  empty_n;
      logic                  full_n;
      logic                  aempty_n;
      logic                  afull_n;
      logic                  dual_n;
      logic                  read_chain_out;
      logic [REG_DATA_W-1:0] rdata;
   } state_s;

   state_s st_reg;
   state_s st_next;
   logic [DATA_W-1:0] mem [DEPTH];
   logic wr_ok;
   logic rd_ok;

   function automatic logic [CW-1:0] fit(input logic [DATA_W-1:0] d);
      fit = d[CW-1:0];
   endfunction

   always_comb
   begin
      logic          can_w;
      logic          can_r;
      logic          rewind;
      logic          pass_w;
      logic [CW-1:0] cnt_flag;
      can_w    = 1'b0;
      can_r    = 1'b0;
      rewind   = 1'b0;
      pass_w   = 1'b0;
      cnt_flag = '0;
      st_next  = st_reg;
      // Token ownership only matters when chained
      can_w = !st_reg.cascade || st_reg.wown;
      can_r = !st_reg.cascade || st_reg.rown;
      rewind = RETRANSMIT_STROBE && !st_reg.cascade;
      wr_ok = !WRITE_EN_N && OFFSET_LOAD_N && can_w
              && (st_reg.count != DEPTH_C);
      rd_ok = !READ_EN_N && OFFSET_LOAD_N && can_r && !rewind
              && (st_reg.count != '0);
      // Offset register: first access hits almost-empty, then almost-full
      if (!OFFSET_LOAD_N && !WRITE_EN_N)
      begin
         if (!st_reg.ld_wsel)
            st_next.ae_off = fit(DATA_IN);
         else
            st_next.af_off = fit(DATA_IN);
         st_next.ld_wsel = !st_reg.ld_wsel;
      end
      if (!OFFSET_LOAD_N && !READ_EN_N)
      begin
         st_next.q = DATA_W'(st_reg.ld_rsel ? st_reg.af_off
                                            : st_reg.ae_off);
         st_next.ld_rsel = !st_reg.ld_rsel;
      end
      if (wr_ok)
         st_next.wptr = st_reg.wptr + 1'b1;
      if (rd_ok)
      begin
         st_next.q    = mem[st_reg.rptr];
         st_next.rptr = st_reg.rptr + 1'b1;
      end
      // One clock holds both pointers, so no torn value is ever seen
      case ({wr_ok, rd_ok})
         2'b10:   st_next.count = st_reg.count + 1'b1;
         2'b01:   st_next.count = st_reg.count - 1'b1;
         default: st_next.count = st_reg.count;
      endcase
      // Rewind assumes no more than DEPTH words written since reset
      if (rewind)
      begin
         st_next.rptr  = '0;
         st_next.count = st_next.count + CW'(st_reg.rptr);
      end
      // Tokens move on after the last location is used
      pass_w = st_reg.cascade && wr_ok && (st_reg.wptr == LAST_C);
      if (pass_w)
         st_next.wown = 1'b0;
      else if (WRITE_CHAIN_IN)
         st_next.wown = 1'b1;
      st_next.read_chain_out = st_reg.cascade && rd_ok && (st_reg.rptr == LAST_C);
      if (st_next.read_chain_out)
         st_next.rown = 1'b0;
      else if (READ_CHAIN_IN)
         st_next.rown = 1'b1;
      st_next.empty_n = (st_next.count != '0);
      st_next.full_n  = (st_next.count != DEPTH_C);
      cnt_flag = FLAG_SYNC_SELECT ? st_next.count : st_reg.count;
      st_next.aempty_n = !(cnt_flag <= st_next.ae_off);
      st_next.afull_n  = !((DEPTH_C - cnt_flag) <= st_next.af_off);
      if (st_reg.cascade)
         st_next.dual_n = !pass_w;
      else
         st_next.dual_n = !(st_next.count > HALF_C);
      st_next.oe_n = OUTPUT_ENABLE_N;
      if (REG_WR && REG_ADDR == CTRL_ADDR)
         st_next.cascade = REG_WDATA[CTRL_CASCADE_BIT];
      st_next.rdata = '0;
      if (REG_RD)
      begin
         case (REG_ADDR)
            CTRL_ADDR:
               st_next.rdata[CTRL_CASCADE_BIT] = st_reg.cascade;
            STATUS_ADDR:
            begin
               st_next.rdata[ST_EMPTY_BIT]  = !st_reg.empty_n;
               st_next.rdata[ST_FULL_BIT]   = !st_reg.full_n;
               st_next.rdata[ST_AEMPTY_BIT] = !st_reg.aempty_n;
               st_next.rdata[ST_AFULL_BIT]  = !st_reg.afull_n;
               st_next.rdata[ST_HALF_BIT]   = st_reg.count > HALF_C;
               st_next.rdata[ST_WOWN_BIT]   = st_reg.wown;
               st_next.rdata[ST_ROWN_BIT]   = st_reg.rown;
            end
            COUNT_ADDR:
               st_next.rdata[CW-1:0] = st_reg.count;
            OFFSET_ADDR:
            begin
               st_next.rdata[CW-1:0] = st_reg.ae_off;
               st_next.rdata[OFF_AF_LSB +: CW] = st_reg.af_off;
            end
            default:
               st_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         st_reg          <= '0;
         st_reg.ae_off   <= OFF_RST_C;
         st_reg.af_off   <= OFF_RST_C;
         st_reg.cascade  <= CTRL_CASCADE_RST;
         // Strap caught by a clocked reset; a sync reset may sample it
         st_reg.wown     <= !FIRST_LOAD_N;
         st_reg.rown     <= !FIRST_LOAD_N;
         st_reg.oe_n     <= 1'b1;
         st_reg.full_n   <= 1'b1;
         st_reg.afull_n  <= 1'b1;
         st_reg.dual_n   <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Storage needs no reset; flags guard every read of it
   always_ff @(posedge CLK)
   begin
      if (RESETN && wr_ok)
         mem[st_reg.wptr] <= DATA_IN;
   end

   assign DATA_OUT            = st_reg.q;
   assign DATA_OUT_OE_N       = st_reg.oe_n;
   assign EMPTY_FLAG_N        = st_reg.empty_n;
   assign FULL_FLAG_N         = st_reg.full_n;
   assign ALMOST_EMPTY_FLAG_N = st_reg.aempty_n;
   assign ALMOST_FULL_FLAG_N  = st_reg.afull_n;
   assign CHAIN_OR_HALF_N     = st_reg.dual_n;
   assign READ_CHAIN_OUT      = st_reg.read_chain_out;
   assign REG_RDATA           = st_reg.rdata;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   empty_flag_a: assert property (EMPTY_FLAG_N == (st_reg.count != '0))
      else $error("empty flag disagrees with count");
   full_flag_a: assert property (FULL_FLAG_N == (st_reg.count != DEPTH_C))
      else $error("full flag disagrees with count");
   full_write_a: assert property (
      (st_reg.count == DEPTH_C && !rd_ok)
      |=> st_reg.count == DEPTH_C && $stable(st_reg.wptr))
      else $error("write into full buffer changed state");
   empty_read_a: assert property (
      (st_reg.count == '0 && !RETRANSMIT_STROBE)
      |=> $stable(st_reg.rptr))
      else $error("read from empty buffer moved pointer");
   write_count_a: assert property (
      (!WRITE_EN_N && OFFSET_LOAD_N && !st_reg.cascade && READ_EN_N
       && !RETRANSMIT_STROBE && st_reg.count < DEPTH_C)
      |=> st_reg.count == $past(st_reg.count) + 1'b1)
      else $error("write did not raise count");
   read_data_a: assert property (
      rd_ok |=> DATA_OUT == $past(mem[st_reg.rptr]))
      else $error("read returned wrong word");
   load_read_a: assert property (
      (!OFFSET_LOAD_N && !READ_EN_N && !st_reg.ld_rsel)
      |=> DATA_OUT == DATA_W'($past(st_reg.ae_off)))
      else $error("offset readback wrong");
   load_write_a: assert property (
      (!OFFSET_LOAD_N && !WRITE_EN_N) |=> $stable(st_reg.wptr))
      else $error("offset load moved write pointer");
   half_flag_a: assert property (
      !st_reg.cascade && !$past(st_reg.cascade)
      |-> CHAIN_OR_HALF_N == !(st_reg.count > HALF_C))
      else $error("half flag wrong");
   sync_aempty_a: assert property (
      (!FLAG_SYNC_SELECT && $stable(st_reg.ae_off))
      |=> ALMOST_EMPTY_FLAG_N == !($past(st_reg.count) <= st_reg.ae_off))
      else $error("registered almost-empty wrong");
   async_aempty_a: assert property (
      FLAG_SYNC_SELECT |=>
      ALMOST_EMPTY_FLAG_N == !(st_reg.count <= st_reg.ae_off))
      else $error("direct almost-empty wrong");
   oe_follow_a: assert property (
      RESETN |=> DATA_OUT_OE_N == $past(OUTPUT_ENABLE_N))
      else $error("output enable not followed");
   // Full-side mirrors of the almost-empty checks
   async_afull_a: assert property (
      FLAG_SYNC_SELECT |=>
      ALMOST_FULL_FLAG_N == !((DEPTH_C - st_reg.count) <= st_reg.af_off))
      else $error("direct almost-full wrong");
   sync_afull_a: assert property (
      !FLAG_SYNC_SELECT |=> ALMOST_FULL_FLAG_N
      == !((DEPTH_C - $past(st_reg.count)) <= st_reg.af_off))
      else $error("registered almost-full wrong");
   read_count_a: assert property (
      rd_ok && !wr_ok |=> st_reg.count == $past(st_reg.count) - 1'b1)
      else $error("read did not lower count");
   read_hold_a: assert property (
      (!rd_ok && OFFSET_LOAD_N) |=> $stable(DATA_OUT))
      else $error("output word moved without a read");
   write_store_a: assert property (
      wr_ok |=> mem[$past(st_reg.wptr)] == $past(DATA_IN))
      else $error("written word not stored");
   count_bound_a: assert property (st_reg.count <= DEPTH_C)
      else $error("count above depth");
   load_af_read_a: assert property (
      (!OFFSET_LOAD_N && !READ_EN_N && st_reg.ld_rsel)
      |=> DATA_OUT == DATA_W'($past(st_reg.af_off)))
      else $error("second offset readback wrong");
   load_ae_write_a: assert property (
      (!OFFSET_LOAD_N && !WRITE_EN_N && !st_reg.ld_wsel)
      |=> st_reg.ae_off == $past(DATA_IN[CW-1:0]))
      else $error("almost-empty offset not loaded");
   load_af_write_a: assert property (
      (!OFFSET_LOAD_N && !WRITE_EN_N && st_reg.ld_wsel)
      |=> st_reg.af_off == $past(DATA_IN[CW-1:0]))
      else $error("almost-full offset not loaded");
   load_count_a: assert property (
      (!OFFSET_LOAD_N && !RETRANSMIT_STROBE) |=> $stable(st_reg.count))
      else $error("offset access changed count");
   // Retransmit and chain checks; owner_block_a, write_token_a and read_token_a fire only once cascading is switched on
   rewind_ptr_a: assert property (
      (RETRANSMIT_STROBE && !st_reg.cascade) |=> st_reg.rptr == '0)
      else $error("retransmit did not rewind");
   owner_block_a: assert property (
      (st_reg.cascade && !st_reg.wown && !WRITE_EN_N)
      |=> $stable(st_reg.wptr))
      else $error("write taken without ownership");
   write_token_a: assert property (
      (wr_ok && st_reg.cascade && st_reg.wptr == LAST_C)
      |=> !CHAIN_OR_HALF_N && !st_reg.wown)
      else $error("write token not passed");
   read_token_a: assert property (
      (rd_ok && st_reg.cascade && st_reg.rptr == LAST_C)
      |=> READ_CHAIN_OUT && !st_reg.rown)
      else $error("read token not passed");
   read_quiet_a: assert property (
      !st_reg.cascade |=> !READ_CHAIN_OUT)
      else $error("read token while standalone");
   write_regain_a: assert property (
      (WRITE_CHAIN_IN && !wr_ok) |=> st_reg.wown)
      else $error("write ownership not regained");
   read_regain_a: assert property (
      (READ_CHAIN_IN && !rd_ok) |=> st_reg.rown)
      else $error("read ownership not regained");
   // Register port checks; read data stands for one cycle only
   rdata_idle_a: assert property (
      !REG_RD |=> REG_RDATA == '0)
      else $error("read data outside a read cycle");
   count_read_a: assert property (
      (REG_RD && REG_ADDR == COUNT_ADDR)
      |=> REG_RDATA == REG_DATA_W'($past(st_reg.count)))
      else $error("count readback wrong");
   offset_read_a: assert property (
      (REG_RD && REG_ADDR == OFFSET_ADDR)
      |=> REG_RDATA[CW-1:0] == $past(st_reg.ae_off)
          && REG_RDATA[OFF_AF_LSB +: CW] == $past(st_reg.af_off))
      else $error("offset register readback wrong");
   ctrl_write_a: assert property (
      (REG_WR && REG_ADDR == CTRL_ADDR)
      |=> st_reg.cascade == $past(REG_WDATA[CTRL_CASCADE_BIT]))
      else $error("cascade control not written");
endmodule // flag_fifo
`default_nettype wire

// File: hdl/flag_fifo_pkg.sv
// Constants shared by the flagged FIFO block
package flag_fifo_pkg;
   localparam int DATA_W        = 18;
   localparam int DEPTH_DEF     = 64;
   localparam int REG_ADDR_W    = 4;
   localparam int REG_DATA_W    = 32;
   // Register byte addresses
   localparam logic [3:0] CTRL_ADDR    = 4'h0;
   localparam logic [3:0] STATUS_ADDR  = 4'h4;
   localparam logic [3:0] COUNT_ADDR   = 4'h8;
   localparam logic [3:0] OFFSET_ADDR  = 4'hc;
   // Field positions
   localparam int CTRL_CASCADE_BIT  = 0;
   localparam int ST_EMPTY_BIT      = 0;
   localparam int ST_FULL_BIT       = 1;
   localparam int ST_AEMPTY_BIT     = 2;
   localparam int ST_AFULL_BIT      = 3;
   localparam int ST_HALF_BIT       = 4;
   localparam int ST_WOWN_BIT       = 5;
   localparam int ST_ROWN_BIT       = 6;
   localparam int OFF_AF_LSB        = 16;
   // Reset values
   localparam logic CTRL_CASCADE_RST = 1'b0;
   localparam int   OFFSET_RST       = 7;
endpackage : flag_fifo_pkg

// File: testbench/chain_peer.sv
// Neighbour device in a two-device cascade ring that returns tokens
`timescale 1ns/1ps
`default_nettype none
module chain_peer
#(
   parameter int LAG = 4
)(
   input  wire logic CLK,
   input  wire logic RESETN,
   input  wire logic cascade_on,
   input  wire logic wr_tok_out_n,
   input  wire logic rd_tok_out,
   output var  logic wr_tok_in,
   output var  logic rd_tok_in
);
   logic [LAG-1:0] wdly_reg;
   logic [LAG-1:0] rdly_reg;
   // Tokens come back after LAG cycles; inputs stay low when standalone
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         wdly_reg <= '0;
         rdly_reg <= '0;
      end
      else
      begin
         wdly_reg <= {wdly_reg[LAG-2:0], cascade_on & ~wr_tok_out_n};
         rdly_reg <= {rdly_reg[LAG-2:0], cascade_on & rd_tok_out};
      end
   end
   assign wr_tok_in = wdly_reg[LAG-1];
   assign rd_tok_in = rdly_reg[LAG-1];
endmodule // chain_peer
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the flagged FIFO
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flag_fifo_pkg::*;
   localparam int DEPTH = 8;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              we_n = 1'b1;
   logic              re_n = 1'b1;
   logic              ld_n = 1'b1;
   logic              oe_in_n = 1'b0;
   logic              fl_n = 1'b0;
   logic              retx = 1'b0;
   logic              sync_sel = 1'b1;
   logic              rwr = 1'b0;
   logic              rrd = 1'b0;
   logic              casc = 1'b0;
   logic [DATA_W-1:0] din = '0;
   logic [3:0]        radr = '0;
   logic [31:0]       rwd = '0;
   logic [31:0]       rdata;
   logic [31:0]       q;
   logic [DATA_W-1:0] dout;
   logic [DATA_W-1:0] q_bus;
   logic              oe_n;
   logic              ef;
   logic              ff;
   logic              ae;
   logic              af;
   logic              hf;
   logic              read_chain_out;
   logic              write_chain_in;
   logic              read_chain_in;
   int                errors = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   int                wtok = 0;
   int                rtok = 0;

   always #20 clk = ~clk;
   // Released bus floats so a stale word can never pass for a driven one
   assign q_bus = oe_n ? 'z : dout;

   flag_fifo #(.DEPTH(DEPTH)) dut_u (
      .CLK(clk), .RESETN(resetn), .WRITE_EN_N(we_n), .DATA_IN(din),
      .READ_EN_N(re_n), .DATA_OUT(dout), .DATA_OUT_OE_N(oe_n),
      .OUTPUT_ENABLE_N(oe_in_n), .OFFSET_LOAD_N(ld_n),
      .EMPTY_FLAG_N(ef), .FULL_FLAG_N(ff), .ALMOST_EMPTY_FLAG_N(ae),
      .ALMOST_FULL_FLAG_N(af), .CHAIN_OR_HALF_N(hf),
      .READ_CHAIN_OUT(read_chain_out), .WRITE_CHAIN_IN(write_chain_in), .READ_CHAIN_IN(read_chain_in),
      .FIRST_LOAD_N(fl_n), .RETRANSMIT_STROBE(retx),
      .FLAG_SYNC_SELECT(sync_sel), .REG_ADDR(radr), .REG_WDATA(rwd),
      .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdata));

   chain_peer #(.LAG(4)) peer_u (
      .CLK(clk), .RESETN(resetn), .cascade_on(casc), .wr_tok_out_n(hf),
      .rd_tok_out(read_chain_out), .wr_tok_in(write_chain_in), .rd_tok_in(read_chain_in));

   always @(posedge clk)
   begin
      cycles++;
      if (casc && !hf) wtok++;
      if (casc && read_chain_out) rtok++;
      if (cycles == 20000)
      begin
         errors++;
         summarize();
      end
   end

   task automatic summarize();
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rst();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
   endtask

   // One enable pattern for one edge, then everything released
   task automatic op(input logic w, input logic r, input logic l,
                     input logic [DATA_W-1:0] d);
      @(posedge clk);
      we_n <= w;
      re_n <= r;
      ld_n <= l;
      din <= d;
      @(posedge clk);
      we_n <= 1'b1;
      re_n <= 1'b1;
      ld_n <= 1'b1;
      #1;
   endtask

   task automatic reg_io(input logic w, input logic [3:0] a,
                         input logic [31:0] d);
      @(posedge clk);
      radr <= a;
      rwd <= d;
      rwr <= w;
      rrd <= !w;
      @(posedge clk);
      rwr <= 1'b0;
      rrd <= 1'b0;
      #1;
      q = rdata;
   endtask

   task automatic t_reset();
      chk("flags", 32'h0b, {ef, ff, ae, af, hf});
      reg_io(1'b0, STATUS_ADDR, 32'h0);
      chk("status", 32'h05, q & 32'h1f);
      reg_io(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask

   task automatic t_flags();
      op(1'b0, 1'b1, 1'b0, 18'h00002);
      op(1'b0, 1'b1, 1'b0, 18'h00003);
      op(1'b1, 1'b0, 1'b0, 18'h0);
      chk("ae_off", 32'h2, dout);
      op(1'b1, 1'b0, 1'b0, 18'h0);
      chk("af_off", 32'h3, dout);
      reg_io(1'b0, OFFSET_ADDR, 32'h0);
      chk("offsets", 32'h00030002, q);
      for (int i = 1; i <= 8; i++)
      begin
         op(1'b0, 1'b1, 1'b1, 18'h00100 + i);
         chk("flags", {1'b1, i < 8, i > 2, i < 5, i <= 4},
             {ef, ff, ae, af, hf});
      end
      reg_io(1'b0, COUNT_ADDR, 32'h0);
      chk("count", 32'h8, q);
      op(1'b0, 1'b1, 1'b1, 18'h3ffff);
      for (int i = 1; i <= 8; i++)
      begin
         op(1'b1, 1'b0, 1'b1, 18'h0);
         chk("data", 32'h100 + i, dout);
         chk("empty", i < 8, ef);
      end
      op(1'b1, 1'b0, 1'b1, 18'h0);
      chk("stale", 32'h108, dout);
   endtask

   task automatic t_retx();
      for (int i = 0; i < 3; i++) op(1'b0, 1'b1, 1'b1, 18'h00020 + i);
      op(1'b1, 1'b0, 1'b1, 18'h0);
      @(posedge clk);
      retx <= 1'b1;
      @(posedge clk);
      retx <= 1'b0;
      op(1'b1, 1'b0, 1'b1, 18'h0);
      chk("rewind", 32'h20, dout);
   endtask

   task automatic t_sync();
      @(posedge clk);
      sync_sel <= 1'b0;
      for (int i = 0; i < 8; i++) op(1'b0, 1'b1, 1'b1, 18'h00040 + i);
      chk("ae_lag", 32'h0, ae);
      @(posedge clk);
      #1;
      chk("ae_sync", 32'h1, ae);
      @(posedge clk);
      sync_sel <= 1'b1;
   endtask

   task automatic t_oe();
      @(posedge clk);
      oe_in_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("bus_off", 18'hzzzzz, q_bus);
      @(posedge clk);
      oe_in_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("bus_on", 32'h0, q_bus);
   endtask

   task automatic t_cascade();
      @(posedge clk);
      fl_n <= 1'b1;
      rst();
      reg_io(1'b1, CTRL_ADDR, 32'h1);
      op(1'b0, 1'b1, 1'b1, 18'h00011);
      chk("no_owner", 32'h0, ef);
      @(posedge clk);
      fl_n <= 1'b0;
      rst();
      reg_io(1'b1, CTRL_ADDR, 32'h1);
      casc = 1'b1;
      for (int i = 0; i < 8; i++) op(1'b0, 1'b1, 1'b1, 18'h00060 + i);
      repeat (8) @(posedge clk);
      chk("wr_token", 32'h1, wtok);
      for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 1'b1, 18'h0);
      repeat (8) @(posedge clk);
      chk("rd_token", 32'h1, rtok);
      op(1'b0, 1'b1, 1'b1, 18'h00055);
      op(1'b1, 1'b0, 1'b1, 18'h0);
      chk("regained", 32'h55, dout);
   endtask

   initial
   begin
      rst();
      #1;
      t_reset();
      t_flags();
      rst();
      t_retx();
      rst();
      t_sync();
      t_oe();
      t_cascade();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
